/* File: afc_ctrl.sv */
// apb-controlled driver of an asynchronous fifo through its pins
`include "afc_defs.svh"
module afc_ctrl (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        arst_n,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  // fifo control pins
  output logic             reset_n_in,
  output logic             write_n,
  output logic             read_n,
  output logic             reread_pulse_n,
  output logic             cascade_token_in_n,
  output logic [8:0]       write_word_in,
  // fifo answer pins
  input  wire logic [8:0]  read_word_out,
  input  wire logic        empty_flag_n,
  input  wire logic        full_flag_n,
  input  wire logic        half_full_flag_n
);
  afc_pkg::afc_state_t state_reg;
  logic [3:0]  cnt_reg;
  logic [2:0]  flag_m_reg;
  logic [2:0]  flag_s_reg;
  logic [8:0]  data_m_reg;
  logic [8:0]  data_s_reg;
  logic [8:0]  rdata_reg;
  logic [1:0]  cfg_reg;
  logic        pwr_ok_reg;
  logic        refused_reg;
  logic [10:0] wr_cnt_reg;
  logic [3:0]  high_cnt_reg;
  logic        wr_en;
  logic        acc;
  logic        cmd_rst;
  logic        cmd_rd;
  logic        cmd_rt;
  logic        cmd_wr;
  logic        can_go;
  logic        refuse_set;
  logic        rt_unsafe;

  function automatic logic afc_hit(input logic [11:0] a, input logic [11:0] o);
    afc_hit = (a == o);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      flag_m_reg <= 3'h0;
      flag_s_reg <= 3'h0;
      data_m_reg <= 9'h000;
      data_s_reg <= 9'h000;
    end else begin
      flag_m_reg <= {half_full_flag_n, full_flag_n, empty_flag_n};
      flag_s_reg <= flag_m_reg;
      data_m_reg <= read_word_out;
      data_s_reg <= data_m_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb decode
  assign acc     = psel && penable && pready;
  assign wr_en   = acc && pwrite;
  assign cmd_rst = wr_en && afc_hit(paddr, `AFC_OFS_CTRL) &&
                   pwdata[`AFC_CTRL_RESET];
  assign cmd_rd  = wr_en && afc_hit(paddr, `AFC_OFS_CTRL) &&
                   pwdata[`AFC_CTRL_READ];
  assign cmd_rt  = wr_en && afc_hit(paddr, `AFC_OFS_CTRL) &&
                   pwdata[`AFC_CTRL_REREAD];
  assign cmd_wr  = wr_en && afc_hit(paddr, `AFC_OFS_WDATA);
  // reread is advisory past this many writes, so it is refused instead
  assign rt_unsafe = (wr_cnt_reg > 11'(`AFC_DEPTH));
  assign can_go  = (state_reg == afc_pkg::ST_IDLE) && pwr_ok_reg;
  // full flag high means room; empty flag high means data
  assign refuse_set = (cmd_wr && !(can_go && flag_s_reg[1])) ||
                      (cmd_rd && !(can_go && flag_s_reg[0])) ||
                      (cmd_rt && !(can_go && !cfg_reg[`AFC_CFG_CASCADE] &&
                                   !rt_unsafe)) ||
                      (cmd_rst && state_reg != afc_pkg::ST_IDLE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable &&
                 !(afc_hit(paddr, `AFC_OFS_CTRL) ||
                   afc_hit(paddr, `AFC_OFS_WDATA) ||
                   afc_hit(paddr, `AFC_OFS_RDATA) ||
                   afc_hit(paddr, `AFC_OFS_STATUS) ||
                   afc_hit(paddr, `AFC_OFS_CFG));
      if (psel && !penable) begin
        if (afc_hit(paddr, `AFC_OFS_RDATA))
          prdata <= {23'h000000, rdata_reg};
        else if (afc_hit(paddr, `AFC_OFS_STATUS))
          prdata <= {25'h0000000, rt_unsafe, pwr_ok_reg, refused_reg,
                     flag_s_reg, state_reg != afc_pkg::ST_IDLE};
        else if (afc_hit(paddr, `AFC_OFS_CFG))
          prdata <= {30'h00000000, cfg_reg};
        else
          prdata <= 32'h0000_0000;
      end
    end
  end

  // a refusal in the cycle of a clear still sticks
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      refused_reg <= 1'b0;
    else if (refuse_set)
      refused_reg <= 1'b1;
    else if (wr_en && afc_hit(paddr, `AFC_OFS_CTRL) &&
             pwdata[`AFC_CTRL_CLRREF])
      refused_reg <= 1'b0;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      cfg_reg <= `AFC_CFG_RESET;
    else if (wr_en && afc_hit(paddr, `AFC_OFS_CFG))
      cfg_reg <= pwdata[1:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // pin sequencer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= afc_pkg::ST_RST;
      cnt_reg   <= 4'(`AFC_RESET_CYC - 1);
    end else begin
      unique case (state_reg)
        afc_pkg::ST_IDLE: begin
          if (cmd_rst) begin
            state_reg <= afc_pkg::ST_RST;
            cnt_reg   <= 4'(`AFC_RESET_CYC - 1);
          end else if (cmd_wr && can_go && flag_s_reg[1]) begin
            state_reg <= afc_pkg::ST_WLOW;
            cnt_reg   <= 4'(`AFC_STROBE_CYC - 1);
          end else if (cmd_rd && can_go && flag_s_reg[0]) begin
            state_reg <= afc_pkg::ST_RLOW;
            cnt_reg   <= 4'(`AFC_RLOW_CYC - 1);
          end else if (cmd_rt && !refuse_set) begin
            state_reg <= afc_pkg::ST_TLOW;
            cnt_reg   <= 4'(`AFC_REREAD_CYC - 1);
          end
        end
        afc_pkg::ST_RST, afc_pkg::ST_WLOW, afc_pkg::ST_RLOW,
        afc_pkg::ST_TLOW: begin
          if (cnt_reg == 4'h0) begin
            cnt_reg <= 4'(`AFC_REC_CYC - 1);
            unique case (state_reg)
              afc_pkg::ST_RST:  state_reg <= afc_pkg::ST_RREC;
              afc_pkg::ST_WLOW: state_reg <= afc_pkg::ST_WREC;
              afc_pkg::ST_RLOW: state_reg <= afc_pkg::ST_RDREC;
              default:          state_reg <= afc_pkg::ST_TREC;
            endcase
          end else begin
            cnt_reg <= cnt_reg - 4'h1;
          end
        end
        afc_pkg::ST_RREC, afc_pkg::ST_WREC, afc_pkg::ST_RDREC,
        afc_pkg::ST_TREC: begin
          if (cnt_reg == 4'h0)
            state_reg <= afc_pkg::ST_IDLE;
          else
            cnt_reg <= cnt_reg - 4'h1;
        end
        default: begin
          state_reg <= afc_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // strobes only fall from idle, so both stay high in reset and reread unless READ is set in the same CTRL write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      write_n        <= 1'b1;
      read_n         <= 1'b1;
      reset_n_in     <= 1'b0;
      reread_pulse_n <= 1'b1;
    end else begin
      write_n    <= !(cmd_wr && can_go && flag_s_reg[1]) &&
                    !(state_reg == afc_pkg::ST_WLOW && cnt_reg != 4'h0);
      read_n     <= !(cmd_rd && can_go && flag_s_reg[0]) &&
                    !(state_reg == afc_pkg::ST_RLOW && cnt_reg != 4'h0);
      reset_n_in <= !((state_reg == afc_pkg::ST_IDLE && cmd_rst) ||
                      (state_reg == afc_pkg::ST_RST && cnt_reg != 4'h0));
      if (cfg_reg[`AFC_CFG_CASCADE] &&
          (state_reg == afc_pkg::ST_IDLE && cmd_rst))
        reread_pulse_n <= cfg_reg[`AFC_CFG_FIRST_N];
      else if (!cascade_token_in_n || !cfg_reg[`AFC_CFG_CASCADE])
        reread_pulse_n <= !((state_reg == afc_pkg::ST_IDLE && cmd_rt &&
                             !refuse_set) ||
                            (state_reg == afc_pkg::ST_TLOW &&
                             cnt_reg != 4'h0));
    end
  end

  // straps only change as a reset starts, so they are steady while sampled
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      cascade_token_in_n <= 1'b0;
    else if (state_reg == afc_pkg::ST_IDLE && cmd_rst)
      cascade_token_in_n <= cfg_reg[`AFC_CFG_CASCADE];
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      write_word_in <= 9'h000;
    else if (cmd_wr && can_go && flag_s_reg[1])
      write_word_in <= pwdata[8:0];
  end

  // data is taken at the end of the low phase, after access and sync time
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      rdata_reg <= 9'h000;
    else if (state_reg == afc_pkg::ST_RLOW && cnt_reg == 4'h0)
      rdata_reg <= data_s_reg;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      pwr_ok_reg <= 1'b0;
    else if (state_reg == afc_pkg::ST_RREC && cnt_reg == 4'h0)
      pwr_ok_reg <= 1'b1;
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      wr_cnt_reg <= 11'h000;
    else if (state_reg == afc_pkg::ST_RST)
      wr_cnt_reg <= 11'h000;
    else if (state_reg == afc_pkg::ST_WLOW && cnt_reg == 4'h0 &&
             !rt_unsafe)
      wr_cnt_reg <= wr_cnt_reg + 11'h001;
  end

  // helper for checks: cycles both strobes have been high, saturating
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n)
      high_cnt_reg <= 4'h0;
    else if (!write_n || !read_n)
      high_cnt_reg <= 4'h0;
    else if (high_cnt_reg != 4'hf)
      high_cnt_reg <= high_cnt_reg + 4'h1;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_no_access_before_reset;
    @(posedge clock) disable iff (!arst_n)
      !pwr_ok_reg |-> write_n && read_n;
  endproperty
  a_no_access_before_reset: assert property (p_no_access_before_reset)
    else $error("strobe moved before first reset completed");

  property p_strobes_high_before_reset_rise;
    @(posedge clock) disable iff (!arst_n)
      $rose(reset_n_in) |-> high_cnt_reg >= 4'(`AFC_STROBE_CYC);
  endproperty
  a_strobes_high_before_reset_rise: assert property (p_strobes_high_before_reset_rise)
    else $error("strobes not high long enough before reset release");

  property p_write_only_with_room;
    @(posedge clock) disable iff (!arst_n)
      $fell(write_n) |-> $past(flag_s_reg[1]) ##1 !write_n [*8];
  endproperty
  a_write_only_with_room: assert property (p_write_only_with_room)
    else $error("write strobe fell while full or too short");

  property p_reread_strobes_idle;
    @(posedge clock) disable iff (!arst_n)
      !cascade_token_in_n && !reread_pulse_n |-> write_n && read_n;
  endproperty
  a_reread_strobes_idle: assert property (p_reread_strobes_idle)
    else $error("strobe low during reread pulse");

  property p_reread_write_limit;
    @(posedge clock) disable iff (!arst_n)
      !cascade_token_in_n && $fell(reread_pulse_n) |->
        wr_cnt_reg <= 11'(`AFC_DEPTH);
  endproperty
  a_reread_write_limit: assert property (p_reread_write_limit)
    else $error("reread issued after too many writes");

  property p_standalone_strap;
    @(posedge clock) disable iff (!arst_n)
      !reset_n_in && !cfg_reg[`AFC_CFG_CASCADE] && !$past(reset_n_in)
        |-> !cascade_token_in_n;
  endproperty
  a_standalone_strap: assert property (p_standalone_strap)
    else $error("cascade strap not grounded in standalone reset");

  property p_first_load_steady;
    @(posedge clock) disable iff (!arst_n)
      cascade_token_in_n && $past(cascade_token_in_n) |->
        $stable(reread_pulse_n);
  endproperty
  a_first_load_steady: assert property (p_first_load_steady)
    else $error("first-load strap moved in cascade mode");

  c_write: cover property (@(posedge clock) disable iff (!arst_n)
    $fell(write_n));
  c_read: cover property (@(posedge clock) disable iff (!arst_n)
    $rose(read_n) ##[1:8] state_reg == afc_pkg::ST_IDLE);
  c_reread: cover property (@(posedge clock) disable iff (!arst_n)
    $fell(reread_pulse_n) && !cascade_token_in_n);
  c_reset: cover property (@(posedge clock) disable iff (!arst_n)
    $rose(reset_n_in) && pwr_ok_reg);
endmodule

/* File: afc_defs.svh */
// constants of the fifo pin controller: offsets, fields, timing counts
//
// Summary of operation
// - Controller pulses the buffer reset once after power-up, before any access.
// - Both strobes stand high at least one strobe width before reset rises; after one CTRL write setting READ with RESET, read_n is high one cycle less.
// - A write begins at the write strobe fall, only while full reads high.
// - Both strobes stay high for the whole reread pulse; read_n falls with it when READ and REREAD are set in one CTRL write.
// - Reread is used only after at most 1024 writes since reset.
// - Grounding the cascade input strap selects standalone operation.
// - Cascade ring: exactly one device has its first-load strap low.
`ifndef AFC_DEFS_SVH
`define AFC_DEFS_SVH
`define AFC_OFS_CTRL      12'h000
`define AFC_OFS_WDATA     12'h004
`define AFC_OFS_RDATA     12'h008
`define AFC_OFS_STATUS    12'h00c
`define AFC_OFS_CFG       12'h010
`define AFC_CTRL_RESET    0
`define AFC_CTRL_READ     1
`define AFC_CTRL_REREAD   2
`define AFC_CTRL_CLRREF   3
`define AFC_CFG_CASCADE   0
`define AFC_CFG_FIRST_N   1
`define AFC_CFG_RESET     2'h0
`define AFC_WORD_W        9
`define AFC_DEPTH         1024
`define AFC_CLK_NS        8
`define AFC_STROBE_NS     80
`define AFC_ACCESS_NS     80
`define AFC_RECOVER_NS    15
`define AFC_RESET_NS      80
`define AFC_REREAD_NS     80
`define AFC_SYNC_CYC      2
`define AFC_CEIL(ns)      (((ns) + `AFC_CLK_NS - 1) / `AFC_CLK_NS)
`define AFC_STROBE_CYC    `AFC_CEIL(`AFC_STROBE_NS)
`define AFC_RLOW_CYC      (`AFC_CEIL(`AFC_ACCESS_NS) + `AFC_SYNC_CYC)
`define AFC_REC_CYC       (`AFC_CEIL(`AFC_RECOVER_NS) + `AFC_SYNC_CYC)
`define AFC_RESET_CYC     `AFC_CEIL(`AFC_RESET_NS)
`define AFC_REREAD_CYC    `AFC_CEIL(`AFC_REREAD_NS)
`endif

/* File: afc_fifo_model.sv */
// behavioural model of the nine-bit asynchronous fifo seen at its pins
module afc_fifo_model #(
  parameter int DEPTH     = 1024,
  parameter int ACCESS_NS = 60
) (
  // strobes and straps
  input  wire logic       reset_n_in,
  input  wire logic       write_n,
  input  wire logic       read_n,
  input  wire logic       reread_pulse_n,
  input  wire logic       cascade_token_in_n,
  input  wire logic [8:0] write_word_in,
  // data and flags
  output logic      [8:0] read_word_out,
  output logic            empty_flag_n,
  output logic            full_flag_n,
  output logic            half_full_flag_n
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] mem [DEPTH];
  logic [8:0] q;
  int         wp = 0;
  int         rp = 0;
  int         cnt = 0;
  int         wtot = 0;
  logic       cascade = 1'h0;
  logic       first_n = 1'h0;
  logic       w_ok = 1'h0;
  logic       w_held = 1'h0;
  logic       r_held = 1'h0;
  initial read_word_out = 9'h155;
  ////////////////////////////////////////////////////////////////////////////
  always @(negedge reset_n_in) begin
    wp = 0;
    rp = 0;
    cnt = 0;
    wtot = 0;
  end
  always @(posedge reset_n_in) begin
    cascade = cascade_token_in_n;
    first_n = reread_pulse_n;
  end
  // write side looks at the read side only to pass a word to a read held low on empty
  always @(negedge write_n) begin
    w_ok = reset_n_in && full_flag_n;
    w_held = reset_n_in && !full_flag_n;
  end
  always @(posedge write_n) begin
    if ((w_ok || (w_held && full_flag_n)) && reset_n_in) begin
      mem[wp] = write_word_in;
      wp = (wp + 1) % DEPTH;
      cnt++;
      wtot++;
      // only the first word flows to a read held low on empty
      if (r_held && !read_n) begin
        read_word_out = mem[rp];
        rp = (rp + 1) % DEPTH;
        cnt--;
      end
      r_held = 1'h0;
    end
    w_ok = 1'h0;
    w_held = 1'h0;
  end
  // only the device holding the turn answers
  always @(negedge read_n) begin
    r_held = reset_n_in && !empty_flag_n;
    if (reset_n_in && empty_flag_n && !(cascade && first_n)) begin
      q = mem[rp];
      rp = (rp + 1) % DEPTH;
      cnt--;
      #ACCESS_NS;
      if (!read_n) read_word_out = q;
    end
  end
  // released bus shows a changing pattern, never the old word
  always @(posedge read_n) begin
    r_held = 1'h0;
    read_word_out = ~read_word_out;
  end
  always @(negedge reread_pulse_n)
    if (reset_n_in && !cascade) begin
      rp = 0;
      cnt = (wtot < DEPTH) ? wtot : DEPTH;
    end
  assign empty_flag_n = (cnt != 0);
  assign full_flag_n = (cnt != DEPTH);
  // shared pin carries no half flag when cascaded
  assign half_full_flag_n = cascade || (cnt <= DEPTH / 2);
endmodule

/* File: afc_pkg.sv */
// types of the fifo pin controller
package afc_pkg;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_RST   = 9'h002,
    ST_RREC  = 9'h004,
    ST_WLOW  = 9'h008,
    ST_WREC  = 9'h010,
    ST_RLOW  = 9'h020,
    ST_RDREC = 9'h040,
    ST_TLOW  = 9'h080,
    ST_TREC  = 9'h100
  } afc_state_t;
endpackage

/* File: test_afc_ctrl.sv */
// self-checking bench of the apb fifo pin controller
`include "afc_defs.svh"
module test_afc_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock = 1'h0;
  logic        arst_n = 1'h0;
  logic        psel = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite = 1'h0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, reset_n_in, write_n, read_n, last_err;
  logic        reread_pulse_n, cascade_token_in_n, empty_flag_n;
  logic        full_flag_n, half_full_flag_n;
  logic [8:0]  write_word_in, read_word_out;
  int          errors = 0;
  int          num_checks = 0;
  always #4 clock = ~clock;
  afc_ctrl i_afc_ctrl (.clock, .arst_n, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pready, .prdata, .pslverr, .reset_n_in, .write_n, .read_n,
    .reread_pulse_n, .cascade_token_in_n, .write_word_in, .read_word_out,
    .empty_flag_n, .full_flag_n, .half_full_flag_n);
  afc_fifo_model i_afc_fifo_model (.reset_n_in, .write_n, .read_n,
    .reread_pulse_n, .cascade_token_in_n, .write_word_in, .read_word_out,
    .empty_flag_n, .full_flag_n, .half_full_flag_n);
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp, input string m);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clock);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'h0;
    @(posedge clock);
    penable <= 1'h1;
    n = 0;
    // values seen here are those sampled at this rising edge
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (pready !== 1'h1) begin
      chk(32'h0, 32'h1, "no apb answer");
      stop_test;
    end else begin
      r = prdata;
      last_err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask
  // polls status until ready and not busy
  task automatic idle;
    logic [31:0] s;
    int n;
    n = 0;
    do begin
      apb(1'h0, `AFC_OFS_STATUS, 32'h0, s);
      n++;
    end while ((s & 32'h21) !== 32'h20 && n < 100);
    if (n >= 100) begin
      chk(32'h0, 32'h1, "controller stays busy");
      stop_test;
    end
  endtask
  task automatic cmd(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    apb(1'h1, a, d, r);
    idle;
  endtask
  task automatic st(input logic [31:0] mask, exp, input string m);
    logic [31:0] s;
    apb(1'h0, `AFC_OFS_STATUS, 32'h0, s);
    chk(s & mask, exp, m);
  endtask
  task automatic rd_word(input logic [8:0] exp);
    logic [31:0] r;
    cmd(`AFC_OFS_CTRL, 32'h2);
    apb(1'h0, `AFC_OFS_RDATA, 32'h0, r);
    chk(r, {23'h0, exp}, "word read back");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge reset_n_in)
    chk({30'h0, write_n, read_n}, 32'h3, "strobe low at reset end");
  always @(negedge reread_pulse_n)
    if (cascade_token_in_n === 1'h0)
      chk({30'h0, write_n, read_n}, 32'h3, "strobe low in reread");
  task automatic t_basic;
    logic [31:0] r;
    logic [8:0] w [3] = '{9'h1a5, 9'h05a, 9'h100};
    idle;
    st(32'h3f, 32'h2c, "flags after power-up");
    apb(1'h0, 12'h014, 32'h0, r);
    chk({31'h0, last_err}, 32'h1, "unmapped address accepted");
    foreach (w[i]) begin
      cmd(`AFC_OFS_WDATA, {23'h0, w[i]});
      chk({23'h0, write_word_in}, {23'h0, w[i]}, "data pins");
    end
    st(32'h3f, 32'h2e, "empty after writes");
    foreach (w[i]) rd_word(w[i]);
    st(32'h3f, 32'h2c, "not empty after drain");
    cmd(`AFC_OFS_CTRL, 32'h2);
    st(32'h12, 32'h10, "read on empty taken");
    cmd(`AFC_OFS_CTRL, 32'h8);
    st(32'h10, 32'h0, "refused not cleared");
    $display("basic done");
  endtask
  task automatic t_reread;
    cmd(`AFC_OFS_CTRL, 32'h1);
    cmd(`AFC_OFS_WDATA, 32'h0f0);
    cmd(`AFC_OFS_WDATA, 32'h00f);
    rd_word(9'h0f0);
    cmd(`AFC_OFS_CTRL, 32'h4);
    st(32'h12, 32'h02, "reread flags");
    rd_word(9'h0f0);
    rd_word(9'h00f);
    $display("reread done");
  endtask
  task automatic t_fill;
    cmd(`AFC_OFS_CTRL, 32'h1);
    st(32'h3f, 32'h2c, "fifo reset command");
    for (int i = 0; i < `AFC_DEPTH; i++) begin
      cmd(`AFC_OFS_WDATA, 32'(i) ^ 32'h155);
      if (i == 511) st(32'h8, 32'h8, "half too early");
      if (i == 512) st(32'h8, 32'h0, "half not set");
    end
    st(32'h1c, 32'h00, "full not set");
    cmd(`AFC_OFS_WDATA, 32'h0aa);
    st(32'h10, 32'h10, "write on full taken");
    cmd(`AFC_OFS_CTRL, 32'h8);
    rd_word(9'h155);
    st(32'h0c, 32'h04, "full not released");
    cmd(`AFC_OFS_CTRL, 32'h4);
    st(32'h1c, 32'h00, "flags after full reread");
    rd_word(9'h155);
    cmd(`AFC_OFS_WDATA, 32'h0aa);
    st(32'h50, 32'h40, "reread limit not flagged");
    cmd(`AFC_OFS_CTRL, 32'h4);
    st(32'h50, 32'h50, "reread past limit taken");
    cmd(`AFC_OFS_CTRL, 32'h8);
    $display("fill done");
  endtask
  task automatic t_cascade;
    logic [31:0] r;
    cmd(`AFC_OFS_CFG, 32'h1);
    cmd(`AFC_OFS_CTRL, 32'h1);
    apb(1'h0, `AFC_OFS_CFG, 32'h0, r);
    chk(r & 32'h3, 32'h1, "cfg readback");
    chk({30'h0, cascade_token_in_n, reread_pulse_n}, 32'h2,
        "straps");
    cmd(`AFC_OFS_CTRL, 32'h4);
    st(32'h10, 32'h10, "reread taken in cascade");
    cmd(`AFC_OFS_CTRL, 32'h8);
    cmd(`AFC_OFS_WDATA, 32'h1c3);
    rd_word(9'h1c3);
    $display("cascade done");
  endtask
  initial begin
    repeat (3) @(posedge clock);
    @(negedge clock);
    chk({31'h0, reset_n_in}, 32'h0, "fifo reset pin high");
    @(posedge clock);
    arst_n <= 1'h1;
    t_basic;
    t_reread;
    t_fill;
    t_cascade;
    stop_test;
  end
endmodule
